// ### gated_timer.sv
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "gated_timer_params.svh"

module gated_timer
  import gated_timer_pkg::*;
#(
  parameter int PRESC_W = 3
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        gate_pin,
  input  wire logic        ext_count_input,
  input  wire logic        secondary_osc_in,
  input  wire logic        low_freq_internal_osc,
  output logic             irq
);

  // pin synchronisers: s1 feeds only s2
  // all stages reset low like the idle pins, so no false edge follows reset
  logic [`PIN_COUNT-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [`PIN_COUNT-1:0] s1_d, filt_d, pin_rise, pin_fall;

  // bus slave
  logic        waitrequest_q, waitrequest_d;
  logic [31:0] readdata_q, readdata_d;
  logic        wr_acc;
  byte_t       wbyte;

  // registers
  count_t      count_q, count_d;
  byte_t       ctrl_q, ctrl_d;
  byte_t       gctl_q, gctl_d;
  byte_t       irq_en_q, irq_en_d;
  byte_t       irq_stat_q, irq_stat_d;
  logic        irq_q, irq_d;

  // counting engine
  logic [1:0]         div_q, div_d;
  logic [PRESC_W-1:0] presc_q, presc_d, presc_last;
  logic               armed_q, armed_d;
  logic               ext_pend_q, ext_pend_d;
  logic               gate_act_q, gate_act_d;
  logic               disarm;

  logic       instr_tick, src_tick, count_en, gate_ok;
  logic       ext_rise, ext_fall, ext_tick, inc;
  logic       on_bit, async_bit, sosc_bit, gate_en, gate_pol;
  logic [1:0] clk_sel, presc_sel;
  logic       wr_low, wr_high, wr_ctrl, count_write, ovf_event, gate_event;

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;
  assign irq         = irq_q;

  assign on_bit    = ctrl_q[`CTL_ON_BIT];
  assign async_bit = ctrl_q[`CTL_ASYNC_BIT];
  assign sosc_bit  = ctrl_q[`CTL_SOSC_EN_BIT];
  assign presc_sel = ctrl_q[`CTL_PRESC_LSB +: 2];
  assign clk_sel   = ctrl_q[`CTL_CS_LSB +: 2];
  assign gate_en   = gctl_q[`GCTL_EN_BIT];
  assign gate_pol  = gctl_q[`GCTL_POL_BIT];

  // ---------------- synchronisers ----------------
  always_comb begin
    s1_d = '0;
    s1_d[`PIN_GATE]  = gate_pin;
    s1_d[`PIN_EXT]   = ext_count_input;
    s1_d[`PIN_SOSC]  = secondary_osc_in;
    s1_d[`PIN_LFOSC] = low_freq_internal_osc;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      // a level is believed only once stages two and three agree
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
    end
    pin_rise = filt_d & ~filt_q;
    pin_fall = ~filt_d & filt_q;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ---------------- bus slave ----------------
  // one wait cycle: request seen, then waitrequest low for one cycle
  // the wait state costs a cycle per access but lets both outputs leave flops
  always_comb begin
    waitrequest_d = 1'b1;
    readdata_d    = readdata_q;
    if ((read || write) && waitrequest_q) begin
      waitrequest_d = 1'b0;
      // a write leaves the last read data standing
      if (read) begin
        readdata_d = '0;
        unique case (address)
          `OFS_COUNT_LOW:       readdata_d[7:0] = count_q[7:0];
          `OFS_COUNT_HIGH:      readdata_d[7:0] = count_q[15:8];
          `OFS_COUNTER_CONTROL: readdata_d[7:0] = ctrl_q;
          `OFS_GATE_CONTROL: begin
            readdata_d[7:0] = gctl_q;
            readdata_d[`GCTL_VALUE_BIT] = gate_ok;
          end
          `OFS_IRQ_ENABLE:      readdata_d[7:0] = irq_en_q;
          `OFS_IRQ_STATUS:      readdata_d[7:0] = irq_stat_q;
          default:              readdata_d = '0;
        endcase
      end
    end
  end

  assign wr_acc  = write && !waitrequest_q && byteenable[0];
  assign wbyte   = writedata[7:0];
  assign wr_low  = wr_acc && (address == `OFS_COUNT_LOW);
  assign wr_high = wr_acc && (address == `OFS_COUNT_HIGH);
  assign wr_ctrl = wr_acc && (address == `OFS_COUNTER_CONTROL);
  assign count_write = wr_low || wr_high;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      waitrequest_q <= 1'b1;
      readdata_q    <= '0;
    end else begin
      waitrequest_q <= waitrequest_d;
      readdata_q    <= readdata_d;
    end
  end

  // ---------------- counting engine ----------------
  // limitation: even the asynchronous count input passes the pin filter, so
  // each level must last two clocks or the edge is lost
  assign gate_ok  = (filt_q[`PIN_GATE] == gate_pol);
  assign count_en = on_bit && (!gate_en || gate_ok);
  assign instr_tick = (div_q == `INSTR_DIV_LAST);
  // secondary oscillator enable picks which pin feeds select 10
  assign ext_rise = sosc_bit ? pin_rise[`PIN_SOSC] : pin_rise[`PIN_EXT];
  assign ext_fall = sosc_bit ? pin_fall[`PIN_SOSC] : pin_fall[`PIN_EXT];
  // a stopped counter or a count write forgets every edge seen so far
  assign disarm   = !on_bit || count_write;

  always_comb begin
    div_d      = div_q + 2'h1;
    armed_d    = armed_q;
    ext_pend_d = ext_pend_q;
    ext_tick   = 1'b0;
    // no counting until a falling edge follows enable, write or disable
    if (disarm) begin
      armed_d    = 1'b0;
      ext_pend_d = 1'b0;
    end else if (ext_fall) begin
      armed_d = 1'b1;
    end else if (ext_rise && armed_q) begin
      if (async_bit) begin
        ext_tick = 1'b1;
      end else begin
        ext_pend_d = 1'b1;
      end
    end
    // synced mode releases the edge on the instruction boundary
    if (!async_bit && ext_pend_q && instr_tick && on_bit && !count_write) begin
      ext_tick   = 1'b1;
      // an edge caught in this same cycle stays pending for the next boundary
      if (!(ext_rise && armed_q)) begin
        ext_pend_d = 1'b0;
      end
    end

    unique case (clk_sel)
      `CS_INSTR:    src_tick = instr_tick;
      `CS_SYSCLK:   src_tick = 1'b1;
      `CS_EXTERNAL: src_tick = ext_tick;
      `CS_LFOSC:    src_tick = pin_rise[`PIN_LFOSC];
    endcase
  end

  // prescaler divides by 1, 2, 4 or 8
  // cleared only by count or control writes, so the first period after the
  // gate reopens in mid-run may come out short
  assign presc_last = PRESC_W'((1 << presc_sel) - 1);

  always_comb begin
    presc_d = presc_q;
    inc     = 1'b0;
    if (count_write || wr_ctrl) begin
      presc_d = '0;
    end else if (count_en && src_tick) begin
      if (presc_q >= presc_last) begin
        presc_d = '0;
        inc     = 1'b1;
      end else begin
        presc_d = presc_q + PRESC_W'(1);
      end
    end
  end

  always_comb begin
    count_d   = count_q;
    ovf_event = 1'b0;
    // a software write wins over a tick landing in the same cycle
    // the bytes are not latched together: read high, low, high to catch a carry
    if (count_write) begin
      if (wr_low)  count_d[7:0]  = wbyte;
      if (wr_high) count_d[15:8] = wbyte;
    end else if (inc) begin
      count_d   = count_q + 16'h0001;
      ovf_event = (count_q == `COUNT_ALL_ONES);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_q      <= '0;
      presc_q    <= '0;
      armed_q    <= 1'b0;
      ext_pend_q <= 1'b0;
      count_q    <= `RST_COUNT;
    end else begin
      div_q      <= div_d;
      presc_q    <= presc_d;
      armed_q    <= armed_d;
      ext_pend_q <= ext_pend_d;
      count_q    <= count_d;
    end
  end

  // ---------------- control, enables, status ----------------
  always_comb begin
    ctrl_d     = ctrl_q;
    gctl_d     = gctl_q;
    irq_en_d   = irq_en_q;
    irq_stat_d = irq_stat_q;
    // only a window that was open counts, so a gate shut at enable is no event
    gate_act_d = count_en && gate_en;
    // acquisition ends when an enabled gate window closes
    gate_event = gate_act_q && on_bit && gate_en && !gate_ok;
    if (wr_ctrl) begin
      ctrl_d = wbyte & `CTL_WR_MASK;
    end
    if (wr_acc && address == `OFS_GATE_CONTROL) begin
      gctl_d = wbyte & `GCTL_WR_MASK;
    end
    if (wr_acc && address == `OFS_IRQ_ENABLE) begin
      irq_en_d = wbyte & `IRQ_EN_WR_MASK;
    end
    if (wr_acc && address == `OFS_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~(wbyte & `IRQ_STAT_MASK);
    end
    // set beats a same-cycle write-one-to-clear
    if (ovf_event)  irq_stat_d[`IRQ_OVF_BIT]  = 1'b1;
    if (gate_event) irq_stat_d[`IRQ_GATE_BIT] = 1'b1;
    // one clock of lag buys an irq straight off a flop
    irq_d = |(irq_stat_q & irq_en_q & `IRQ_STAT_MASK);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q     <= `RST_BYTE;
      gctl_q     <= `RST_BYTE;
      irq_en_q   <= `RST_BYTE;
      irq_stat_q <= `RST_BYTE;
      gate_act_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      gctl_q     <= gctl_d;
      irq_en_q   <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      gate_act_q <= gate_act_d;
      irq_q      <= irq_d;
    end
  end

endmodule : gated_timer

// ### gated_timer_params.svh
`ifndef GATED_TIMER_PARAMS_SVH
`define GATED_TIMER_PARAMS_SVH

// byte addresses of the word-aligned registers
`define OFS_COUNT_LOW        5'h00
`define OFS_COUNT_HIGH       5'h04
`define OFS_COUNTER_CONTROL  5'h08
`define OFS_GATE_CONTROL     5'h0C
`define OFS_IRQ_ENABLE       5'h10
`define OFS_IRQ_STATUS       5'h14

// counter_control_reg fields
`define CTL_ON_BIT           0
`define CTL_ASYNC_BIT        2
`define CTL_SOSC_EN_BIT      3
`define CTL_PRESC_LSB        4
`define CTL_CS_LSB           6
`define CTL_WR_MASK          8'hFD

// gate_control_reg fields
`define GCTL_VALUE_BIT       2
`define GCTL_POL_BIT         6
`define GCTL_EN_BIT          7
`define GCTL_WR_MASK         8'hC0

// interrupt enable and status layout
`define IRQ_OVF_BIT          0
`define IRQ_GATE_BIT         7
`define IRQ_EN_WR_MASK       8'hFB
`define IRQ_STAT_MASK        8'h81

// clock_select codes
`define CS_INSTR             2'b00
`define CS_SYSCLK            2'b01
`define CS_EXTERNAL          2'b10
`define CS_LFOSC             2'b11

// reset values and the count overflow value
`define RST_BYTE             8'h00
`define RST_COUNT            16'h0000
`define COUNT_ALL_ONES       16'hFFFF

// last divider count; four system clocks per instruction cycle
`define INSTR_DIV_LAST       2'h3

// pin positions inside the synchroniser vector
`define PIN_GATE             0
`define PIN_EXT              1
`define PIN_SOSC             2
`define PIN_LFOSC            3
`define PIN_COUNT            4

`endif

// ### gated_timer_pkg.sv
package gated_timer_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] count_t;
  typedef logic [4:0]  addr_t;

endpackage : gated_timer_pkg

// ### gated_timer_assertions.sv
`timescale 1ns/100ps
`include "gated_timer_params.svh"

module gated_timer_assertions
  import gated_timer_pkg::*;
#(
  parameter int PRESC_W = 3
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        gate_pin,
  input wire logic        ext_count_input,
  input wire logic        secondary_osc_in,
  input wire logic        low_freq_internal_osc,
  input wire logic        irq
);
  logic [7:0] en_seen_q;
  logic [7:0] en_seen_d;
  logic       en_hit;

  // mirror of the enable register, taken at the same edge as the write
  assign en_hit = write && !waitrequest && address == `OFS_IRQ_ENABLE && byteenable[0];
  always_comb begin
    en_seen_d = en_hit ? writedata[7:0] : en_seen_q;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) en_seen_q <= 8'h00;
    else en_seen_q <= en_seen_d;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  no_spurious_a: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without request");
  read_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  unmapped_a: assert property (read && waitrequest && address > 5'h14 |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_bit1_a: assert property (read && waitrequest && address == `OFS_COUNTER_CONTROL
    |=> !readdata[1])
    else $error("control bit1 not zero");
  data_hold_a: assert property ($changed(readdata) |-> !waitrequest && $past(read))
    else $error("read data changed without read");
  irq_mask_a: assert property (irq |-> ($past(en_seen_q) & 8'h81) != 8'h00)
    else $error("irq high while masked");
  irq_off_a: assert property (en_hit && (writedata[7:0] & 8'h81) == 8'h00 |-> ##2 !irq)
    else $error("irq stays after masking");
endmodule : gated_timer_assertions

bind gated_timer gated_timer_assertions #(.PRESC_W(PRESC_W)) i_gated_timer_assertions (.*);

// ### osc_model.sv
`timescale 1ns/100ps

// free oscillator on a pin; stands low while not running
module osc_model #(
  parameter int HALF = 4
) (
  input wire logic clock,
  input wire logic run,
  output logic     pin
);
  int cnt_q;

  // held low by run during reset, so the pin needs no second driver
  always @(posedge clock) begin
    if (!run) begin
      pin <= 1'b0;
      cnt_q <= 0;
    end else if (cnt_q == HALF - 1) begin
      pin <= ~pin;
      cnt_q <= 0;
    end else cnt_q <= cnt_q + 1;
  end
endmodule : osc_model

// ### gated_timer_test.sv
`timescale 1ns/100ps
`include "gated_timer_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module gated_timer_test
  import gated_timer_pkg::*;
;
  logic        clock, rstn, read, write, gate_pin, waitrequest, irq, osc_run;
  addr_t       address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  wire logic   ext_pin, sosc_pin, lf_pin;
  int          fails, num_checks, cyc;
  byte_t       v, h;
  byte_t       ctl_tab[8] = '{8'h01, 8'h41, 8'h51, 8'h71, 8'hC1, 8'h85, 8'h8D, 8'h81};
  int          lo_tab[8] = '{22, 96, 47, 10, 3, 14, 6, 13};
  int          hi_tab[8] = '{27, 101, 51, 14, 6, 18, 9, 18};

  gated_timer i_gated_timer (.clock(clock), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .gate_pin(gate_pin), .ext_count_input(ext_pin),
    .secondary_osc_in(sosc_pin), .low_freq_internal_osc(lf_pin), .irq(irq));
  // distinct rates so a wrong source pick shows in the count
  osc_model #(.HALF(3)) i_osc_model_ext (.clock(clock), .run(osc_run), .pin(ext_pin));
  osc_model #(.HALF(6)) i_osc_model_sosc (.clock(clock), .run(osc_run), .pin(sosc_pin));
  osc_model #(.HALF(10)) i_osc_model_lf (.clock(clock), .run(osc_run), .pin(lf_pin));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic wr(input addr_t a, input byte_t d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr

  task automatic rd(input addr_t a, output byte_t d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
  endtask : rd

  task automatic run(input byte_t ctl, input int lo, input int hi);
    wr(`OFS_COUNT_LOW, 8'h00);
    wr(`OFS_COUNT_HIGH, 8'h00);
    wr(`OFS_COUNTER_CONTROL, ctl);
    repeat (96) @(posedge clock);
    wr(`OFS_COUNTER_CONTROL, ctl & 8'hFE);
    rd(`OFS_COUNT_LOW, v);
    rd(`OFS_COUNT_HIGH, h);
    `CHK(v >= lo && v <= hi, 1'b1)
    `CHK(h, 8'h00)
  endtask : run

  task final_report;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {rstn, read, write, gate_pin, osc_run} = 5'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    {fails, num_checks, cyc} = '0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    osc_run <= 1'b1;
    wr(5'h18, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      rd(addr_t'(i * 4), v);
      // gate pin low meets reset polarity low, so the gate value bit reads open
      `CHK(v, (i == 3) ? 8'h04 : 8'h00)
    end
    $display("reset test done");
    wr(`OFS_COUNT_LOW, 8'hA5);
    wr(`OFS_COUNT_HIGH, 8'h5A);
    byteenable <= 4'h0;
    wr(`OFS_COUNT_LOW, 8'h33);
    byteenable <= 4'h1;
    wr(`OFS_COUNTER_CONTROL, 8'hFE);
    wr(`OFS_IRQ_ENABLE, 8'hFF);
    rd(`OFS_COUNT_LOW, v);
    `CHK(v, 8'hA5)
    rd(`OFS_COUNT_HIGH, v);
    `CHK(v, 8'h5A)
    rd(`OFS_COUNTER_CONTROL, v);
    `CHK(v, 8'hFC)
    rd(`OFS_IRQ_ENABLE, v);
    `CHK(v, 8'hFB)
    wr(`OFS_COUNTER_CONTROL, 8'h00);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    $display("register test done");
    for (int i = 0; i < 8; i++) run(ctl_tab[i], lo_tab[i], hi_tab[i]);
    $display("source test done");
    wr(`OFS_IRQ_STATUS, 8'hFF);
    wr(`OFS_COUNT_LOW, 8'hF0);
    wr(`OFS_COUNT_HIGH, 8'hFF);
    run(8'h41, 96, 101);
    wr(`OFS_COUNT_LOW, 8'hF0);
    wr(`OFS_COUNT_HIGH, 8'hFF);
    wr(`OFS_COUNTER_CONTROL, 8'h41);
    repeat (40) @(posedge clock);
    wr(`OFS_COUNTER_CONTROL, 8'h40);
    rd(`OFS_IRQ_STATUS, v);
    `CHK(v, 8'h01)
    `CHK(irq, 1'b0)
    wr(`OFS_IRQ_ENABLE, 8'h01);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1)
    wr(`OFS_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    $display("overflow test done");
    wr(`OFS_GATE_CONTROL, 8'hC0);
    run(8'h41, 0, 0);
    gate_pin <= 1'b1;
    run(8'h41, 96, 101);
    wr(`OFS_IRQ_ENABLE, 8'h80);
    wr(`OFS_COUNTER_CONTROL, 8'h41);
    gate_pin <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK(irq, 1'b1)
    rd(`OFS_IRQ_STATUS, v);
    `CHK(v, 8'h80)
    $display("gate test done");
    osc_run <= 1'b0;
    final_report();
  end
endmodule : gated_timer_test
